/* File: design/gpio_port.v */
/*
 gpio port register block: input sampling, output data with set/clear strobes,
 configuration freeze with key sequence, alternate function and drive strength.
 assumes pin inputs already synchronous to sys_clk_i and a one-cycle strobe register port.
*/
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`include "gpio_port_regs.vh"

// Contract
// R1: input register shows sampled pin levels in low 16 bits, read-only.
// R2: output register holds per-pin level, read/write, drives general outputs.
// R3: set/clear write sets low-half ones, clears upper-half ones.
// R4: same pin set and clear together: set wins.
// R5: software uses full word writes on strobe registers; nothing stored.
// R6: clear-only write clears output bits written as one.
// R7: key bit readable always, changes only by key sequence.
// R8: key sequence 1,0,1 then reads give 0 then 1.
// R9: software may skip the final confirming read.
// R10: lock bits must stay equal during sequence; deviation aborts arming.
// R11: once key active, whole freeze register ignores writes until reset.
// R12: per-pin lock bits writable only while key reads 0.
// R13: lock bit one marks pin configuration as locked.
// R14: locked pins ignore configuration writes; data paths unaffected.
// R15: 4-bit alternate function selector per pin, low and high registers.
// R16: 2-bit drive strength per pin output to pad.
// R17: reduced ports implement only listed pins; others read reset value.
// R18: low alternate function register absent or pin 0 only per variant.
// R19: software writes reserved bits with reset values.
// R20: mode 00 input, 01 output, 10 alt function, 11 analog.
module gpio_port #(
    parameter [15:0] PIN_MASK = 16'hffff
) (
    input  wire        sys_clk_i,
    input  wire        resetn_i,
    input  wire [7:0]  addr_i,
    input  wire [31:0] wdata_i,
    input  wire        wr_i,
    input  wire        rd_i,
    output reg  [31:0] rdata_o,
    input  wire [15:0] pin_i,
    output wire [15:0] pin_o,
    output wire [15:0] pin_oe_o,
    output wire [31:0] pin_mode_o,
    output wire [15:0] open_drain_o,
    output wire [15:0] slow_slew_o,
    output wire [31:0] pull_o,
    output wire [63:0] alt_func_o,
    output wire [31:0] drive_strength_o
);

    // ----------------------------------------------------------------
    // per-pin field spreading
    // ----------------------------------------------------------------
    // one bit per pin widened to a 2-bit field per pin
    function [31:0] spread2;
        input [15:0] bits;
        integer f;
        begin
            spread2 = `RST_ZERO32;
            for (f = 0; f < 16; f = f + 1)
                spread2[2*f +: 2] = {2{bits[f]}};
        end
    endfunction

    // one bit per pin widened to a 4-bit field per pin
    function [63:0] spread4;
        input [15:0] bits;
        integer f;
        begin
            spread4 = 64'h0;
            for (f = 0; f < 16; f = f + 1)
                spread4[4*f +: 4] = {4{bits[f]}};
        end
    endfunction

    // constant, so the async reset branch loads no variable
    localparam [31:0] DS_RESET = `RST_DRIVE32 & spread2(PIN_MASK);

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    reg [15:0] pin_input_bits_r;
    reg [15:0] pin_output_bits_r;
    reg [15:0] config_freeze_bits_r;
    reg        freeze_key_r;
    reg [1:0]  key_state_r;
    reg [31:0] mode_r;
    reg [15:0] otype_r;
    reg [15:0] slew_r;
    reg [31:0] pull_r;
    reg [63:0] alt_func_selector_r;
    reg [31:0] drive_strength_field_r;

    // ----------------------------------------------------------------
    // write decode
    // ----------------------------------------------------------------
    wire w_mode   = wr_i && (addr_i == `OFS_PIN_MODE);
    wire w_otype  = wr_i && (addr_i == `OFS_OUT_TYPE);
    wire w_slew   = wr_i && (addr_i == `OFS_SLEW);
    wire w_pull   = wr_i && (addr_i == `OFS_PULL);
    wire w_out    = wr_i && (addr_i == `OFS_PIN_OUTPUT);
    wire w_setclr = wr_i && (addr_i == `OFS_SET_CLEAR);
    wire w_freeze = wr_i && (addr_i == `OFS_CONFIG_FREEZE);
    wire w_afl    = wr_i && (addr_i == `OFS_ALT_FUNC_LOW);
    wire w_afh    = wr_i && (addr_i == `OFS_ALT_FUNC_HIGH);
    wire w_clr    = wr_i && (addr_i == `OFS_CLEAR_STROBE);
    wire w_ds     = wr_i && (addr_i == `OFS_DRIVE_SELECT);
    wire r_freeze = rd_i && (addr_i == `OFS_CONFIG_FREEZE);

    // R13 locked pins
    wire [15:0] locked  = freeze_key_r ? config_freeze_bits_r : 16'h0000;
    // R14 editable fields only
    wire [15:0] free1   = PIN_MASK & ~locked;
    wire [31:0] free2   = spread2(free1);
    wire [63:0] free4   = spread4(free1);

    wire [15:0] set_strobe_bits   = w_setclr ? wdata_i[15:0] : 16'h0000;
    wire [15:0] clear_strobe_bits = (w_setclr ? wdata_i[31:16] : 16'h0000)
                                  | (w_clr ? wdata_i[15:0] : 16'h0000);

    // ----------------------------------------------------------------
    // output data path
    // ----------------------------------------------------------------
    // R3 set and clear strobes
    // R4 set over clear
    // R6 clear-only strobe
    wire [15:0] pod_base = w_out ? wdata_i[15:0] : pin_output_bits_r;
    wire [15:0] pin_output_bits_nxt = ((pod_base & ~clear_strobe_bits) | set_strobe_bits)
                                      & PIN_MASK;

    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_input_bits_r  <= 16'h0000;
            pin_output_bits_r <= 16'h0000;
        end else begin
            // R1 sample inputs
            pin_input_bits_r  <= pin_i & PIN_MASK;
            // R2 store output level
            pin_output_bits_r <= pin_output_bits_nxt;
        end
    end

    // ----------------------------------------------------------------
    // freeze key sequence
    // ----------------------------------------------------------------
    wire       kbit    = wdata_i[`FREEZE_KEY_BIT];
    wire [15:0] wlock  = wdata_i[15:0] & PIN_MASK;
    wire       same    = (wlock == config_freeze_bits_r);
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            config_freeze_bits_r <= 16'h0000;
            freeze_key_r         <= 1'b0;
            key_state_r          <= `KEY_IDLE;
        end else if (freeze_key_r) begin
            // R11 frozen until reset
            key_state_r <= `KEY_IDLE;
        end else if (w_freeze) begin
            // R12 lock bits writable while key is 0
            config_freeze_bits_r <= wlock;
            // R7 key only via sequence
            // R10 changed lock bits abort
            case (key_state_r)
                `KEY_IDLE:  key_state_r <= kbit ? `KEY_GOT1 : `KEY_IDLE;
                `KEY_GOT1:  key_state_r <= (!kbit && same) ? `KEY_GOT10
                                          : (kbit ? `KEY_GOT1 : `KEY_IDLE);
                `KEY_GOT10: key_state_r <= (kbit && same) ? `KEY_GOT101
                                          : `KEY_IDLE;
                default:    key_state_r <= kbit ? `KEY_GOT1 : `KEY_IDLE;
            endcase
        end else if (r_freeze && key_state_r == `KEY_GOT101) begin
            // R8 first read returns 0, then key goes active
            freeze_key_r      <= 1'b1;
            key_state_r       <= `KEY_IDLE;
        end else if (wr_i && key_state_r != `KEY_IDLE) begin
            // R10 foreign write breaks sequence
            key_state_r <= `KEY_IDLE;
        end
    end

    // ----------------------------------------------------------------
    // configuration fields
    // ----------------------------------------------------------------
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mode_r                 <= `RST_MODE32;
            otype_r                <= 16'h0000;
            slew_r                 <= `RST_SLEW16;
            pull_r                 <= `RST_ZERO32;
            alt_func_selector_r    <= 64'h0;
            drive_strength_field_r <= DS_RESET;
        end else begin
            // R14 locked pins keep configuration
            // R20 mode encoding carried to pads
            if (w_mode)
                mode_r <= (mode_r & ~free2) | (wdata_i & free2);
            if (w_otype)
                otype_r <= (otype_r & ~free1) | (wdata_i[15:0] & free1);
            if (w_slew)
                slew_r <= (slew_r & ~free1) | (wdata_i[15:0] & free1);
            if (w_pull)
                pull_r <= (pull_r & ~free2) | (wdata_i & free2);
            // R15 selector per pin
            // R18 low register follows implemented pins
            if (w_afl)
                alt_func_selector_r[31:0] <= (alt_func_selector_r[31:0] & ~free4[31:0])
                                           | (wdata_i & free4[31:0]);
            if (w_afh)
                alt_func_selector_r[63:32] <= (alt_func_selector_r[63:32] & ~free4[63:32])
                                            | (wdata_i & free4[63:32]);
            // R16 drive strength code
            if (w_ds)
                drive_strength_field_r <= (drive_strength_field_r & ~free2) | (wdata_i & free2);
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    // R17 unimplemented pins read reset value; strobes read zero
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_o <= `RST_ZERO32;
        end else if (rd_i) begin
            if (addr_i == `OFS_PIN_MODE)
                rdata_o <= mode_r;
            else if (addr_i == `OFS_OUT_TYPE)
                rdata_o <= {16'h0000, otype_r};
            else if (addr_i == `OFS_SLEW)
                rdata_o <= {16'h0000, slew_r};
            else if (addr_i == `OFS_PULL)
                rdata_o <= pull_r;
            else if (addr_i == `OFS_PIN_INPUT)
                rdata_o <= {16'h0000, pin_input_bits_r};
            else if (addr_i == `OFS_PIN_OUTPUT)
                rdata_o <= {16'h0000, pin_output_bits_r};
            else if (addr_i == `OFS_CONFIG_FREEZE)
                // R8 second read shows the armed key
                rdata_o <= {15'h0000, freeze_key_r, config_freeze_bits_r};
            else if (addr_i == `OFS_ALT_FUNC_LOW)
                rdata_o <= alt_func_selector_r[31:0];
            else if (addr_i == `OFS_ALT_FUNC_HIGH)
                rdata_o <= alt_func_selector_r[63:32];
            else if (addr_i == `OFS_DRIVE_SELECT)
                rdata_o <= drive_strength_field_r;
            else
                rdata_o <= `RST_ZERO32;
        end else begin
            rdata_o <= `RST_ZERO32;
        end
    end

    // ----------------------------------------------------------------
    // pad side
    // ----------------------------------------------------------------
    // R2 general outputs drive stored level
    reg [15:0] oe;
    integer    k;
    always @* begin
        oe = 16'h0000;
        for (k = 0; k < 16; k = k + 1)
            oe[k] = PIN_MASK[k] && (mode_r[2*k +: 2] == `MODE_OUTPUT);
    end
    assign pin_o            = pin_output_bits_r;
    assign pin_oe_o         = oe;
    assign pin_mode_o       = mode_r;
    assign open_drain_o     = otype_r;
    assign slow_slew_o      = slew_r;
    assign pull_o           = pull_r;
    assign alt_func_o       = alt_func_selector_r;
    assign drive_strength_o = drive_strength_field_r;

endmodule // gpio_port

/* File: design/gpio_port_regs.vh */
/*
 register offsets, field positions, reset values and encodings for the gpio port block.
 assumes word-aligned byte addresses on a plain strobe register port.
*/
`ifndef GPIO_PORT_REGS_VH
`define GPIO_PORT_REGS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_PIN_MODE         8'h00
`define OFS_OUT_TYPE         8'h04
`define OFS_SLEW             8'h08
`define OFS_PULL             8'h0c
`define OFS_PIN_INPUT        8'h10
`define OFS_PIN_OUTPUT       8'h14
`define OFS_SET_CLEAR        8'h18
`define OFS_CONFIG_FREEZE    8'h1c
`define OFS_ALT_FUNC_LOW     8'h20
`define OFS_ALT_FUNC_HIGH    8'h24
`define OFS_CLEAR_STROBE     8'h28
`define OFS_DRIVE_SELECT     8'h2c

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define FREEZE_KEY_BIT       16
`define HALF_WIDTH           16
`define RST_ZERO32           32'h00000000
`define RST_DRIVE32          32'h55555555
`define RST_MODE32           32'h00000000
`define RST_SLEW16           16'h0000

// ----------------------------------------------------------------
// key sequence states
// ----------------------------------------------------------------
`define KEY_IDLE             2'h0
`define KEY_GOT1             2'h1
`define KEY_GOT10            2'h2
`define KEY_GOT101           2'h3

// ----------------------------------------------------------------
// pin mode encoding
// ----------------------------------------------------------------
`define MODE_INPUT           2'h0
`define MODE_OUTPUT          2'h1
`define MODE_ALTFUNC         2'h2
`define MODE_ANALOG          2'h3

`endif

/* File: bench/gpio_port_checker.sv */
/*
 assertions on the gpio port register block, seen from its ports.
 assumes a bind to gpio_port and a one-cycle strobe register port.
*/
`timescale 1ns/1ps
module gpio_port_checker #(
    parameter [15:0] PIN_MASK = 16'hffff
) (
    input wire        sys_clk_i,
    input wire        resetn_i,
    input wire [7:0]  addr_i,
    input wire [31:0] wdata_i,
    input wire        wr_i,
    input wire        rd_i,
    input wire [31:0] rdata_o,
    input wire [15:0] pin_i,
    input wire [15:0] pin_o,
    input wire [15:0] pin_oe_o,
    input wire [31:0] pin_mode_o,
    input wire [63:0] alt_func_o
);
// ------------------------------------------
// helpers
// ------------------------------------------
reg        rd_lock_r;
reg        frozen_r;
reg [15:0] lock_r;
wire [63:0] nib_mask;
wire [31:0] lock2;
wire [15:0] oe_exp;
genvar g;
for (g = 0; g < 16; g = g + 1) begin : gen_mask
    assign nib_mask[4*g+:4] = {4{PIN_MASK[g]}};
    assign lock2[2*g+:2]    = {2{lock_r[g]}};
    assign oe_exp[g]        = PIN_MASK[g] && pin_mode_o[2*g+:2] == 2'h1;
end
// freeze only known once a key read shows it
always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
        rd_lock_r <= 1'b0;
        frozen_r  <= 1'b0;
        lock_r    <= 16'h0;
    end else begin
        rd_lock_r <= rd_i && addr_i == 8'h1c;
        if (rd_lock_r && rdata_o[16]) begin
            frozen_r <= 1'b1;
            lock_r   <= rdata_o[15:0];
        end
    end
end
// ------------------------------------------
// assertions
// ------------------------------------------
default clocking @(posedge sys_clk_i); endclocking
default disable iff (!resetn_i);
a_input_read: assert property (
    rd_i && addr_i == 8'h10 && $past(resetn_i, 2)
    |=> rdata_o == {16'h0, $past(pin_i, 2) & PIN_MASK}) else $error("input read wrong");
a_output_write: assert property (
    wr_i && addr_i == 8'h14 |=> pin_o == ($past(wdata_i[15:0]) & PIN_MASK))
    else $error("output write wrong");
a_output_hold: assert property (!wr_i |=> $stable(pin_o)) else $error("output moved");
a_set_wins: assert property (
    wr_i && addr_i == 8'h18 |=> pin_o == ((($past(pin_o) & ~$past(wdata_i[31:16]))
    | $past(wdata_i[15:0])) & PIN_MASK)) else $error("set clear wrong");
a_clear_only: assert property (
    wr_i && addr_i == 8'h28 |=> pin_o == ($past(pin_o) & ~$past(wdata_i[15:0])))
    else $error("clear strobe wrong");
a_unimpl_quiet: assert property (
    (pin_o & ~PIN_MASK) == 16'h0 && (alt_func_o & ~nib_mask) == 64'h0)
    else $error("unimplemented pin set");
a_af_high: assert property (
    wr_i && addr_i == 8'h24 && !frozen_r
    |=> alt_func_o[63:32] == ($past(wdata_i) & nib_mask[63:32])) else $error("af wrong");
a_mode_locked: assert property (
    frozen_r && wr_i |=> ((pin_mode_o ^ $past(pin_mode_o)) & lock2) == 32'h0)
    else $error("locked mode changed");
a_oe_mode: assert property (pin_oe_o == oe_exp) else $error("enable wrong");
c_key_armed: cover property (rd_lock_r && rdata_o[16]);
c_both_bits: cover property (wr_i && addr_i == 8'h18 && (wdata_i[15:0] & wdata_i[31:16]) != 0);
c_locked_wr: cover property (frozen_r && wr_i && addr_i == 8'h00);
endmodule // gpio_port_checker

bind gpio_port gpio_port_checker #(.PIN_MASK(PIN_MASK)) gpio_port_checker_i (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_o(pin_oe_o), .pin_mode_o(pin_mode_o), .alt_func_o(alt_func_o));

/* File: bench/gpio_pad_model.sv */
/*
 pad model: each pad follows the port when enabled, else the outside level.
 assumes the outside level is always driven, so no pad floats.
*/
`timescale 1ns/1ps
module gpio_pad_model (
    input  wire [15:0] pad_out_i,
    input  wire [15:0] pad_oe_i,
    input  wire [15:0] ext_level_i,
    output wire [15:0] pad_in_o
);
assign pad_in_o = (pad_out_i & pad_oe_i) | (ext_level_i & ~pad_oe_i);
endmodule // gpio_pad_model

/* File: bench/test_gpio_port_data_lock_altfunc.sv */
/*
 testbench for the gpio port, built as the reduced fourth port.
 assumes the register port answers reads one cycle after the strobe.
*/
`timescale 1ns/1ps
module test_gpio_port_data_lock_altfunc;
localparam [15:0] MASK = 16'hf001;
reg         sys_clk_i;
reg         resetn_i;
reg         wr_i;
reg         rd_i;
reg  [7:0]  addr_i;
reg  [31:0] wdata_i;
reg  [15:0] ext_level;
wire [31:0] rdata_o;
wire [31:0] pin_mode_o;
wire [15:0] pin_i;
wire [15:0] pin_o;
wire [15:0] pin_oe_o;
wire [63:0] alt_func_o;
wire [15:0] open_drain_o;
wire [15:0] slow_slew_o;
wire [31:0] pull_o;
wire [31:0] drive_strength_o;
integer     fail_count;
integer     checks;
integer     n;
gpio_port #(.PIN_MASK(MASK)) gpio_port_i (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_o(pin_oe_o), .pin_mode_o(pin_mode_o), .open_drain_o(open_drain_o),
    .slow_slew_o(slow_slew_o), .pull_o(pull_o), .alt_func_o(alt_func_o),
    .drive_strength_o(drive_strength_o));
gpio_pad_model gpio_pad_model_i (.pad_out_i(pin_o), .pad_oe_i(pin_oe_o),
    .ext_level_i(ext_level), .pad_in_o(pin_i));
initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
end
// ------------------------------------------
// tasks
// ------------------------------------------
task check32(input string name, input [31:0] exp, input [31:0] got);
    checks = checks + 1;
    if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("FAIL %0s expected %h seen %h", name, exp, got);
    end
endtask
// one transfer per edge, so strobes never toggle twice in a step
task xfer(input w, input r, input [7:0] a, input [31:0] d);
    @(posedge sys_clk_i);
    wr_i <= w;
    rd_i <= r;
    addr_i <= a;
    wdata_i <= d;
endtask
task wr(input [7:0] a, input [31:0] d);
    xfer(1'b1, 1'b0, a, d);
endtask
task rd(input [7:0] a, input [31:0] exp);
    xfer(1'b0, 1'b1, a, 32'h0);
    xfer(1'b0, 1'b0, a, 32'h0);
    #1;
    check32($sformatf("read %h", a), exp, rdata_o);
endtask
task final_report;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
        $display("Finished cleanly");
    else
        $display("Finished with errors");
    $finish;
endtask
initial begin
    repeat (20000) @(posedge sys_clk_i);
    fail_count = fail_count + 1;
    final_report;
end
// ------------------------------------------
// main sequence
// ------------------------------------------
initial begin
    fail_count = 0;
    checks = 0;
    resetn_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 8'h0;
    wdata_i = 32'h0;
    ext_level = 16'ha5a5;
    repeat (16) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    rd(8'h14, 32'h0);
    rd(8'h1c, 32'h0);
    rd(8'h2c, 32'h55000001);
    rd(8'h18, 32'h0);
    rd(8'h40, 32'h0);
    $display("test reset done");
    wr(8'h10, 32'hffffffff);
    wr(8'h00, 32'h05000000);
    wr(8'h14, 32'h0000ffff);
    wr(8'h28, 32'h00001001);
    wr(8'h18, 32'h90001001);
    rd(8'h14, 32'h00007001);
    check32("pin_oe_o", 32'h00003000, {16'h0, pin_oe_o});
    rd(8'h10, 32'h0000b001);
    $display("test data done");
    for (n = 0; n < 16; n = n + 1) begin
        wr(8'h24, n << 28);
        rd(8'h24, n << 28);
    end
    wr(8'h20, 32'hffffffff);
    rd(8'h20, 32'h0000000f);
    for (n = 0; n < 4; n = n + 1) begin
        wr(8'h2c, n << 30);
        rd(8'h2c, n << 30);
    end
    check32("drive_strength_o", 32'hc0000000, drive_strength_o);
    $display("test select done");
    wr(8'h1c, 32'h00011001);
    wr(8'h1c, 32'h00001000);
    wr(8'h1c, 32'h00011001);
    rd(8'h1c, 32'h00001001);
    wr(8'h1c, 32'h00011001);
    wr(8'h1c, 32'h00001001);
    wr(8'h1c, 32'h00011001);
    rd(8'h1c, 32'h00001001);
    rd(8'h1c, 32'h00011001);
    wr(8'h1c, 32'h00000000);
    rd(8'h1c, 32'h00011001);
    wr(8'h00, 32'hffffffff);
    xfer(1'b0, 1'b0, 8'h0, 32'h0);
    #1;
    check32("pin_mode_o", 32'hfd000000, pin_mode_o);
    wr(8'h14, 32'h00000000);
    rd(8'h14, 32'h00000000);
    wr(8'h04, 32'h0000ffff);
    wr(8'h08, 32'h0000ffff);
    wr(8'h0c, 32'hffffffff);
    xfer(1'b0, 1'b0, 8'h0, 32'h0);
    #1;
    check32("open_drain_o", 32'h0000e000, {16'h0, open_drain_o});
    check32("slow_slew_o", 32'h0000e000, {16'h0, slow_slew_o});
    check32("pull_o", 32'hfc000000, pull_o);
    $display("test lock done");
    final_report;
end
endmodule // test_gpio_port_data_lock_altfunc
